//--- dcr_pkg.sv
// Package with register addresses, field positions and reset values of the drive command map.
package dcr_pkg;

	// ----------------------------------------
	// Register addresses.
	// ----------------------------------------
	localparam logic [15:0] ADDR_CMD_WORD = 16'h2000;
	localparam logic [15:0] ADDR_FREQ_CMD = 16'h2001;
	localparam logic [15:0] ADDR_CTRL_WORD = 16'h2002;
	localparam logic [15:0] ADDR_STATUS = 16'h2100;
	// Group numbers from here upward are communication registers, not parameters.
	localparam logic [7:0] PARAM_GROUP_LIMIT = 8'h20;

	// ----------------------------------------
	// Command word field positions.
	// ----------------------------------------
	localparam int OP_LO = 0;
	localparam int DIR_LO = 4;
	localparam int ACC_LO = 6;
	localparam int STEP_LO = 8;
	localparam int SEL_EN_BIT = 12;
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_STOP = 2'h1;
	localparam logic [1:0] OP_RUN = 2'h2;
	localparam logic [1:0] OP_INCH_RUN = 2'h3;
	localparam logic [1:0] DIR_NONE = 2'h0;
	localparam logic [1:0] DIR_FWD = 2'h1;
	localparam logic [1:0] DIR_REV = 2'h2;
	localparam logic [1:0] DIR_CHANGE = 2'h3;

	// ----------------------------------------
	// Control word bits and reset values.
	// ----------------------------------------
	localparam int CTRL_EXT_FAULT_BIT = 0;
	localparam int CTRL_RESET_BIT = 1;
	localparam int CTRL_BASE_BLOCK_BIT = 2;
	localparam logic [1:0] ACC_RST = 2'h0;
	localparam logic [3:0] STEP_RST = 4'h0;
	localparam logic [15:0] FREQ_RST = 16'h0000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	// True when an address falls in the GGnn parameter space.
	function automatic logic is_param(input logic [15:0] addr);
		return addr[15:8] < PARAM_GROUP_LIMIT;
	endfunction

endpackage

//--- dcr_cmd_if.sv
// Interface carrying the decoded command word between decoder and register bank.
`timescale 1ns/1ps
interface dcr_cmd_if;
	logic [15:0] word;
	logic stop;
	logic run;
	logic inch_run;
	logic forward_dir;
	logic reverse_dir;
	logic dir_change;
	logic sel_en;
	logic [1:0] accel_sel;
	logic [3:0] step_sel;

	modport dec (input word, output stop, run, inch_run, forward_dir, reverse_dir, dir_change, sel_en,
		accel_sel, step_sel);
	modport bank (output word, input stop, run, inch_run, forward_dir, reverse_dir, dir_change, sel_en,
		accel_sel, step_sel);
endinterface

//--- dcr_cmd_decode.sv
// Combinational decoder of the 16-bit operation command word.
`timescale 1ns/1ps
module dcr_cmd_decode (
	dcr_cmd_if.dec cmd
);

	// ----------------------------------------
	// Field decode.
	// ----------------------------------------
	logic [1:0] op;
	logic [1:0] dir;

	// Splits the word into operation, direction and selection fields; bits 3-2 and 15-13 are ignored.
	always_comb begin
		op = cmd.word[dcr_pkg::OP_LO +: 2];
		dir = cmd.word[dcr_pkg::DIR_LO +: 2];
		cmd.stop = (op == dcr_pkg::OP_STOP);
		cmd.run = (op == dcr_pkg::OP_RUN) || (op == dcr_pkg::OP_INCH_RUN);
		cmd.inch_run = (op == dcr_pkg::OP_INCH_RUN);
		cmd.forward_dir = (dir == dcr_pkg::DIR_FWD);
		cmd.reverse_dir = (dir == dcr_pkg::DIR_REV);
		cmd.dir_change = (dir == dcr_pkg::DIR_CHANGE);
		cmd.accel_sel = cmd.word[dcr_pkg::ACC_LO +: 2];
		cmd.step_sel = cmd.word[dcr_pkg::STEP_LO +: 4];
		cmd.sel_en = cmd.word[dcr_pkg::SEL_EN_BIT];
	end

endmodule // dcr_cmd_decode

//--- dcr_reg_bank.sv
// Communication register bank of the drive: command, frequency, control and status words.
`timescale 1ns/1ps
module dcr_reg_bank (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] i_param_rdata,
	input wire logic [7:0] i_warn_code,
	input wire logic [7:0] i_fault_code,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	output logic o_param_wr,
	output logic o_param_rd,
	output logic [7:0] o_param_group,
	output logic [7:0] o_param_num,
	output logic [15:0] o_param_wdata,
	output logic o_stop,
	output logic o_run,
	output logic o_inch_run,
	output logic o_dir_reverse,
	output logic [1:0] o_accel_sel,
	output logic [3:0] o_step_sel,
	output logic [15:0] o_freq_cmd,
	output logic o_ext_fault,
	output logic o_fault_reset,
	output logic o_base_block
);

	// ----------------------------------------
	// Command decoder.
	// ----------------------------------------
	dcr_cmd_if cmd ();

	assign cmd.word = i_wdata;

	dcr_cmd_decode u_dec (
		.cmd(cmd)
	);

	// ----------------------------------------
	// Register state.
	// ----------------------------------------
	logic wr_cmd;
	logic wr_freq;
	logic wr_ctrl;
	logic [15:0] rdata_q, rdata_d;
	logic rd_valid_q, rd_valid_d;
	logic param_wr_q, param_wr_d;
	logic param_rd_q, param_rd_d;
	logic [7:0] group_q, group_d;
	logic [7:0] num_q, num_d;
	logic [15:0] pdata_q, pdata_d;
	logic stop_q, stop_d;
	logic run_q, run_d;
	logic inch_q, inch_d;
	logic rev_q, rev_d;
	logic [1:0] accel_q, accel_d;
	logic [3:0] step_q, step_d;
	logic [15:0] freq_q, freq_d;
	logic ext_fault_q, ext_fault_d;
	logic freset_q, freset_d;
	logic bblock_q, bblock_d;

	assign wr_cmd = i_wr_en && (i_addr == dcr_pkg::ADDR_CMD_WORD);
	assign wr_freq = i_wr_en && (i_addr == dcr_pkg::ADDR_FREQ_CMD);
	assign wr_ctrl = i_wr_en && (i_addr == dcr_pkg::ADDR_CTRL_WORD);

	// Computes next register values; run, inch run, stop, fault reset, read valid and parameter strobes are one-cycle events, the rest are held levels.
	always_comb begin
		// Parameter space access splits the address into group and number.
		param_wr_d = i_wr_en && dcr_pkg::is_param(i_addr);
		param_rd_d = i_rd_en && dcr_pkg::is_param(i_addr);
		group_d = group_q;
		num_d = num_q;
		pdata_d = pdata_q;
		if ((i_wr_en || i_rd_en) && dcr_pkg::is_param(i_addr)) begin
			group_d = i_addr[15:8];
			num_d = i_addr[7:0];
			pdata_d = i_wr_en ? i_wdata : pdata_q;
		end
		// Read answer: status word, parameter data, or zero for write-only and unmapped addresses.
		rd_valid_d = i_rd_en;
		rdata_d = rdata_q;
		if (i_rd_en) begin
			if (i_addr == dcr_pkg::ADDR_STATUS) begin
				rdata_d = {i_warn_code, i_fault_code};
			end else if (dcr_pkg::is_param(i_addr)) begin
				rdata_d = i_param_rdata;
			end else begin
				rdata_d = dcr_pkg::DATA_ZERO;
			end
		end
		// Command word events and held selections.
		stop_d = wr_cmd && cmd.stop;
		run_d = wr_cmd && cmd.run;
		inch_d = wr_cmd && cmd.inch_run;
		rev_d = rev_q;
		accel_d = accel_q;
		step_d = step_q;
		if (wr_cmd) begin
			if (cmd.forward_dir) begin
				rev_d = 1'b0;
			end else if (cmd.reverse_dir) begin
				rev_d = 1'b1;
			end else if (cmd.dir_change) begin
				rev_d = !rev_q;
			end
			if (cmd.sel_en) begin
				accel_d = cmd.accel_sel;
				step_d = cmd.step_sel;
			end
		end
		// Frequency command in hundredths of a hertz.
		freq_d = wr_freq ? i_wdata : freq_q;
		// Control word; reserved bits 3 to 15 are dropped.
		ext_fault_d = wr_ctrl ? i_wdata[dcr_pkg::CTRL_EXT_FAULT_BIT] : ext_fault_q;
		freset_d = wr_ctrl && i_wdata[dcr_pkg::CTRL_RESET_BIT];
		bblock_d = wr_ctrl ? i_wdata[dcr_pkg::CTRL_BASE_BLOCK_BIT] : bblock_q;
	end

	// Registers all state with a synchronous active-low reset.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_q <= dcr_pkg::DATA_ZERO;
			rd_valid_q <= 1'b0;
			param_wr_q <= 1'b0;
			param_rd_q <= 1'b0;
			group_q <= 8'h00;
			num_q <= 8'h00;
			pdata_q <= dcr_pkg::DATA_ZERO;
			stop_q <= 1'b0;
			run_q <= 1'b0;
			inch_q <= 1'b0;
			rev_q <= 1'b0;
			accel_q <= dcr_pkg::ACC_RST;
			step_q <= dcr_pkg::STEP_RST;
			freq_q <= dcr_pkg::FREQ_RST;
			ext_fault_q <= 1'b0;
			freset_q <= 1'b0;
			bblock_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rd_valid_q <= rd_valid_d;
			param_wr_q <= param_wr_d;
			param_rd_q <= param_rd_d;
			group_q <= group_d;
			num_q <= num_d;
			pdata_q <= pdata_d;
			stop_q <= stop_d;
			run_q <= run_d;
			inch_q <= inch_d;
			rev_q <= rev_d;
			accel_q <= accel_d;
			step_q <= step_d;
			freq_q <= freq_d;
			ext_fault_q <= ext_fault_d;
			freset_q <= freset_d;
			bblock_q <= bblock_d;
		end
	end

	// Outputs come straight from the registers.
	assign o_rdata = rdata_q;
	assign o_rd_valid = rd_valid_q;
	assign o_param_wr = param_wr_q;
	assign o_param_rd = param_rd_q;
	assign o_param_group = group_q;
	assign o_param_num = num_q;
	assign o_param_wdata = pdata_q;
	assign o_stop = stop_q;
	assign o_run = run_q;
	assign o_inch_run = inch_q;
	assign o_dir_reverse = rev_q;
	assign o_accel_sel = accel_q;
	assign o_step_sel = step_q;
	assign o_freq_cmd = freq_q;
	assign o_ext_fault = ext_fault_q;
	assign o_fault_reset = freset_q;
	assign o_base_block = bblock_q;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	param_split_a: assert property ((i_wr_en && i_addr[15:8] < dcr_pkg::PARAM_GROUP_LIMIT) |=>
		(o_param_wr && o_param_group == $past(i_addr[15:8]) && o_param_num == $past(i_addr[7:0])))
		else $error("Parameter write not split into group and number.");
	op_decode_a: assert property (wr_cmd |=> (o_stop == ($past(i_wdata[1:0]) == 2'h1) &&
		o_run == $past(i_wdata[1]) && o_inch_run == ($past(i_wdata[1:0]) == 2'h3)))
		else $error("Operation field decoded wrongly.");
	dir_change_a: assert property ((wr_cmd && i_wdata[5:4] == 2'h3) |=> o_dir_reverse != $past(o_dir_reverse))
		else $error("Change direction did not flip direction.");
	dir_set_a: assert property ((wr_cmd && i_wdata[5:4] == 2'h2) |=> o_dir_reverse)
		else $error("Reverse direction not taken.");
	accel_sel_a: assert property ((wr_cmd && i_wdata[12]) |=> o_accel_sel == $past(i_wdata[7:6]))
		else $error("Acceleration set not loaded.");
	step_sel_a: assert property ((wr_cmd && i_wdata[12]) |=> o_step_sel == $past(i_wdata[11:8]))
		else $error("Step speed not loaded.");
	sel_hold_a: assert property ((wr_cmd && !i_wdata[12]) |=> $stable(o_step_sel) && $stable(o_accel_sel))
		else $error("Selections changed without enable bit.");
	freq_load_a: assert property (wr_freq |=> o_freq_cmd == $past(i_wdata))
		else $error("Frequency command not loaded.");
	ext_fault_a: assert property ((wr_ctrl && i_wdata[0]) |=> o_ext_fault)
		else $error("External fault not asserted.");
	fault_reset_a: assert property ((wr_ctrl && i_wdata[1]) |=>
		o_fault_reset ##1 (o_fault_reset == $past(wr_ctrl && i_wdata[1])))
		else $error("Fault reset is not a one-cycle event.");
	base_block_a: assert property ((wr_ctrl && i_wdata[2]) |=> o_base_block)
		else $error("Base block not turned on.");
	status_read_a: assert property ((i_rd_en && i_addr == dcr_pkg::ADDR_STATUS) |=>
		(o_rd_valid && o_rdata == {$past(i_warn_code), $past(i_fault_code)}))
		else $error("Status word read wrongly.");

	run_cover_c: cover property (wr_cmd && i_wdata[1:0] == 2'h3 ##1 o_inch_run);
	step_cover_c: cover property (wr_cmd && i_wdata[12] && i_wdata[11:8] == 4'hf);
	fault_cover_c: cover property (o_ext_fault ##[1:20] o_fault_reset);
	status_cover_c: cover property (i_rd_en && i_addr == dcr_pkg::ADDR_STATUS);

endmodule // dcr_reg_bank

//--- dcr_master_model.sv
// Behavioural register-bus master that issues single-word writes and reads.
`timescale 1ns/1ps
module dcr_master_model (
	input wire logic i_clk,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	// Idle bus levels at time zero.
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end

	// One access: launched after an edge, held over the taking edge, then released.
	// Address and data go to their inverse when idle so that stale values are never mistaken for fresh ones.
	task automatic access(input logic wr, input logic rd, input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		#1;
		o_wr_en = wr;
		o_rd_en = rd;
		o_addr = a;
		o_wdata = d;
		@(posedge i_clk);
		#1;
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule // dcr_master_model

//--- tb_drive_command_register_map.sv
// Self-checking testbench of the drive command register bank.
`timescale 1ns/1ps
module tb_drive_command_register_map;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_wr_en, i_rd_en;
	logic [15:0] i_addr, i_wdata, o_rdata, o_param_wdata, o_freq_cmd, w, d;
	logic [15:0] i_param_rdata = 16'h0000;
	logic [7:0] i_warn_code = 8'h00;
	logic [7:0] i_fault_code = 8'h00;
	logic o_rd_valid, o_param_wr, o_param_rd, o_stop, o_run, o_inch_run, o_dir_reverse;
	logic o_ext_fault, o_fault_reset, o_base_block;
	logic [7:0] o_param_group, o_param_num;
	logic [1:0] o_accel_sel;
	logic [3:0] o_step_sel;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int e_dir, e_acc, e_step, op, dir;
	// Expected status-word read answers, queued by the main sequence before each status read.
	logic [15:0] exp_q[$];

	// Clock of 5 ns period.
	always #2.5 i_clk = ~i_clk;

	dcr_reg_bank DUT (.i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_param_rdata,
		.i_warn_code, .i_fault_code, .o_rdata, .o_rd_valid, .o_param_wr, .o_param_rd, .o_param_group,
		.o_param_num, .o_param_wdata, .o_stop, .o_run, .o_inch_run, .o_dir_reverse, .o_accel_sel,
		.o_step_sel, .o_freq_cmd, .o_ext_fault, .o_fault_reset, .o_base_block);

	dcr_master_model u_master (.i_clk(i_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
		.o_wdata(i_wdata));

	// Compares one result with the model and counts it.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// Main sequence.
	initial begin
		w = 16'($urandom(32'hf01b));
		repeat (20) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		check({o_stop, o_run, o_inch_run, o_dir_reverse, o_ext_fault, o_base_block}, 16'h0000);
		check(o_freq_cmd, 16'h0000);
		$display("test reset done");
		// Every operation, direction and step code, with the selection enable set.
		e_dir = 0;
		e_acc = 0;
		e_step = 0;
		for (op = 0; op < 4; op++) begin
			for (dir = 0; dir < 4; dir++) begin
				w = {3'h0, 1'b1, 4'(op * 4 + dir), 2'(op + dir), 2'(dir), 2'h0, 2'(op)};
				u_master.access(1'b1, 1'b0, dcr_pkg::ADDR_CMD_WORD, w);
				if (dir == 1) e_dir = 0;
				else if (dir == 2) e_dir = 1;
				else if (dir == 3) e_dir = 1 - e_dir;
				e_acc = w[7:6];
				e_step = w[11:8];
				check({o_stop, o_run, o_inch_run}, {13'h0, op == 1, op >= 2, op == 3});
				check(o_dir_reverse, e_dir[0]);
				check(o_accel_sel, e_acc[1:0]);
				check(o_step_sel, e_step[3:0]);
			end
		end
		@(posedge i_clk);
		#1;
		check(o_run, 1'b0);
		// Without the enable bit the selections must hold.
		w = 16'($urandom);
		w = {3'h0, 1'b0, w[11:6], 6'h00};
		u_master.access(1'b1, 1'b0, dcr_pkg::ADDR_CMD_WORD, w);
		check(o_accel_sel, e_acc[1:0]);
		check(o_step_sel, e_step[3:0]);
		$display("test command word done");
		repeat (3) begin
			w = 16'($urandom);
			u_master.access(1'b1, 1'b0, dcr_pkg::ADDR_FREQ_CMD, w);
			check(o_freq_cmd, w);
		end
		$display("test frequency done");
		for (op = 0; op < 8; op++) begin
			u_master.access(1'b1, 1'b0, dcr_pkg::ADDR_CTRL_WORD, 16'(op));
			check({o_ext_fault, o_fault_reset, o_base_block}, 16'(op[0] * 4 + op[1] * 2 + op[2]));
		end
		$display("test control word done");
		repeat (4) begin
			i_warn_code = 8'($urandom);
			i_fault_code = 8'($urandom);
			exp_q.push_back({i_warn_code, i_fault_code});
			u_master.access(1'b0, 1'b1, dcr_pkg::ADDR_STATUS, 16'h0000);
			check(o_rd_valid, 1'b1);
			check(o_rdata, exp_q.pop_front());
		end
		// Write-only and unmapped places read as zero.
		for (op = 0; op < 4; op++) begin
			u_master.access(1'b0, 1'b1, (op < 3) ? 16'(16'h2000 + op) : 16'h3000, 16'h0000);
			check(o_rdata, 16'h0000);
		end
		$display("test status done");
		repeat (4) begin
			w = 16'($urandom);
			w[15:13] = 3'h0;
			d = 16'($urandom);
			u_master.access(1'b1, 1'b0, w, d);
			check(o_param_wr, 1'b1);
			check({o_param_group, o_param_num}, w);
			check(o_param_wdata, d);
			i_param_rdata = 16'($urandom);
			u_master.access(1'b0, 1'b1, w, 16'h0000);
			check(o_param_rd, 1'b1);
			check(o_rdata, i_param_rdata);
		end
		$display("test parameter access done");
		report_and_stop();
	end
endmodule // tb_drive_command_register_map
